// *** core/jtag_tap_pkg.sv ***
// Shared constants, opcodes, states and state records of the boundary scan test port.
package jtag_tap_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int IR_W         = 8;
	localparam int ID_W         = 32;
	localparam int IO_COUNT     = 4;
	localparam int CELLS_PER_IO = 3;
	localparam int BSR_W        = IO_COUNT * CELLS_PER_IO;

	// Position of each cell inside the group of three that one pin owns.
	localparam int CELL_IN  = 0;
	localparam int CELL_OUT = 1;
	localparam int CELL_OE  = 2;

	// Consecutive high samples of the mode pin that always reach reset.
	localparam logic [2:0] TMS_RESET_CYCLES = 3'h5;

	// ----------------------------------------------------------------
	// Instruction opcodes
	// ----------------------------------------------------------------
	localparam logic [IR_W-1:0] OP_EXTEST   = 8'h00;
	localparam logic [IR_W-1:0] OP_SAMPLE   = 8'h01;
	localparam logic [IR_W-1:0] OP_CLAMP    = 8'h05;
	localparam logic [IR_W-1:0] OP_HIGHZ    = 8'h07;
	localparam logic [IR_W-1:0] OP_USERCODE = 8'h0e;
	localparam logic [IR_W-1:0] OP_IDCODE   = 8'h0f;
	localparam logic [IR_W-1:0] OP_BYPASS   = 8'hff;

	// Pattern loaded into the instruction shifter on capture.
	localparam logic [IR_W-1:0] IR_CAPTURE  = 8'h01;
	// Fixed least significant bit of the identification word.
	localparam logic            ID_FIXED_LSB = 1'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TLR    = 4'b1111, RTI    = 4'b1100, SEL_DR = 4'b0111, CAP_DR = 4'b0110,
		SH_DR  = 4'b0010, EX1_DR = 4'b0001, PA_DR  = 4'b0011, EX2_DR = 4'b0000,
		UP_DR  = 4'b0101, SEL_IR = 4'b0100, CAP_IR = 4'b1110, SH_IR  = 4'b1010,
		EX1_IR = 4'b1001, PA_IR  = 4'b1011, EX2_IR = 4'b1000, UP_IR  = 4'b1101
	} tap_state_t;

	typedef enum logic [1:0] {
		DR_BYPASS = 2'b00,
		DR_ID     = 2'b01,
		DR_BSR    = 2'b10
	} dr_sel_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jtag_pins_t;

	typedef struct packed {
		tap_state_t          state;
		logic                tck_d;
		logic [IR_W-1:0]     ir_sr;
		logic [IR_W-1:0]     ir;
		logic                bypass;
		logic [ID_W-1:0]     id_sr;
		logic                tdo;
		logic                tdo_oe;
		logic                io_en;
		logic [IO_COUNT-1:0] pad_out;
		logic [IO_COUNT-1:0] pad_oe;
		logic [IO_COUNT-1:0] core_in;
	} tap_regs_t;

	typedef struct packed {
		logic [BSR_W-1:0] sr;
		logic [BSR_W-1:0] upd;
	} bsr_regs_t;

endpackage

// *** core/jtag_pin_sync.sv ***
// Two-stage synchroniser for levels that arrive from pins.
`timescale 1ns/1ns
module jtag_pin_sync #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	// Levels.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// Stage 0 is read only by stage 1, so metastability cannot leak into logic.
	logic [1:0][WIDTH-1:0] stage_r;
	logic [1:0][WIDTH-1:0] stage_nxt;

	always_comb begin
		stage_nxt    = stage_r;
		stage_nxt[0] = async_i;
		stage_nxt[1] = stage_r[0];
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			stage_r <= {RESET_VAL, RESET_VAL};
		end else begin
			stage_r <= stage_nxt;
		end
	end

	assign sync_o = stage_r[1];

endmodule

// *** core/jtag_bsr_chain.sv ***
// Boundary scan chain: serial shifter and parallel update latches, three cells per pin.
`timescale 1ns/1ns
module jtag_bsr_chain (
	// Clock and reset.
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_n_i,
	// Strobes from the controller, one reference cycle each.
	input  wire logic                        capture_i,
	input  wire logic                        shift_i,
	input  wire logic                        update_i,
	// Serial and parallel data.
	input  wire logic                        tdi_i,
	input  wire logic [jtag_tap_pkg::BSR_W-1:0] par_in_i,
	output logic                             so_o,
	output logic      [jtag_tap_pkg::BSR_W-1:0] par_out_o
);
	import jtag_tap_pkg::*;

	bsr_regs_t st_r;
	bsr_regs_t st_nxt;

	// Capture loads every cell at once; shift moves toward cell 0 which feeds TDO.
	always_comb begin
		st_nxt = st_r;
		if (capture_i) begin
			st_nxt.sr = par_in_i;
		end else if (shift_i) begin
			st_nxt.sr = {tdi_i, st_r.sr[BSR_W-1:1]};
		end
		if (update_i) begin
			st_nxt.upd = st_r.sr;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign so_o      = st_r.sr[0];
	assign par_out_o = st_r.upd;

endmodule

// *** core/jtag_tap.sv ***
// Test access port: controller, instruction decode, data registers and pin gating.
//
// Behaviour
// - Sixteen-state controller stepped by TMS on TCK rise.
// - Power-up reset enters Test-Logic-Reset without TCK.
// - Five TMS-high TCK cycles always reach reset.
// - Low TRST forces reset regardless of TCK.
// - Register strobes derive from TMS and TCK.
// - Decode EXTEST 00, SAMPLE 01, BYPASS FF.
// - Decode IDCODE 0F, USERCODE 0E, HIGHZ 07, CLAMP 05.
// - Data registers: bypass, identification, boundary scan.
// - Bypass sits in path when nothing else selected.
// - Identification register: 32 bits, four fields.
// - Three boundary cells per pin.
// - Boundary cells form one TDI-to-TDO chain.
// - Cells capture pins and drive pins from update.
// - Unprogrammed device keeps all user pins disabled.
// - SAMPLE never enables inputs while unprogrammed.
`timescale 1ns/1ns
module jtag_tap #(
	parameter logic [3:0]  ID_VERSION = 4'h1,      // Arbitrary value.
	parameter logic [15:0] ID_PART    = 16'h0001,  // Arbitrary value.
	parameter logic [10:0] ID_MAKER   = 11'h001,   // Arbitrary value.
	parameter logic [31:0] USERCODE   = 32'h0000_0000
) (
	// Clock and reset.
	input  wire logic                             ref_clk_i,
	input  wire logic                             rst_n_i,
	// Test port pins.
	input  wire logic                             tck_i,
	input  wire logic                             tms_i,
	input  wire logic                             tdi_i,
	input  wire logic                             trst_n_i,
	output logic                                  tdo_o,
	output logic                                  tdo_oe_o,
	// Device state.
	input  wire logic                             programmed_i,
	output logic                                  io_en_o,
	// Core side of the user pins.
	input  wire logic [jtag_tap_pkg::IO_COUNT-1:0] core_out_i,
	input  wire logic [jtag_tap_pkg::IO_COUNT-1:0] core_oe_i,
	output logic      [jtag_tap_pkg::IO_COUNT-1:0] core_in_o,
	// Pad side of the user pins.
	input  wire logic [jtag_tap_pkg::IO_COUNT-1:0] pad_in_i,
	output logic      [jtag_tap_pkg::IO_COUNT-1:0] pad_out_o,
	output logic      [jtag_tap_pkg::IO_COUNT-1:0] pad_oe_o
);
	import jtag_tap_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Controller transition on one TCK rise.
	function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
		tap_state_t n;
		n = s;
		unique case (s)
			TLR:    n = tms ? TLR    : RTI;
			RTI:    n = tms ? SEL_DR : RTI;
			SEL_DR: n = tms ? SEL_IR : CAP_DR;
			CAP_DR: n = tms ? EX1_DR : SH_DR;
			SH_DR:  n = tms ? EX1_DR : SH_DR;
			EX1_DR: n = tms ? UP_DR  : PA_DR;
			PA_DR:  n = tms ? EX2_DR : PA_DR;
			EX2_DR: n = tms ? UP_DR  : SH_DR;
			UP_DR:  n = tms ? SEL_DR : RTI;
			SEL_IR: n = tms ? TLR    : CAP_IR;
			CAP_IR: n = tms ? EX1_IR : SH_IR;
			SH_IR:  n = tms ? EX1_IR : SH_IR;
			EX1_IR: n = tms ? UP_IR  : PA_IR;
			PA_IR:  n = tms ? EX2_IR : PA_IR;
			EX2_IR: n = tms ? UP_IR  : SH_IR;
			UP_IR:  n = tms ? SEL_DR : RTI;
		endcase
		return n;
	endfunction

	// Data register that an instruction places between TDI and TDO.
	function automatic dr_sel_t dr_select(input logic [IR_W-1:0] ir);
		dr_sel_t d;
		d = DR_BYPASS;
		if (ir == OP_EXTEST || ir == OP_SAMPLE) begin
			d = DR_BSR;
		end else if (ir == OP_IDCODE || ir == OP_USERCODE) begin
			d = DR_ID;
		end
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and TCK edges
	// ----------------------------------------------------------------
	localparam jtag_pins_t PINS_RESET = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
	localparam logic [ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_LSB};

	jtag_pins_t          pins_raw;
	jtag_pins_t          pins;
	logic [IO_COUNT-1:0] pad_in_s;
	tap_regs_t           st_r;
	tap_regs_t           st_nxt;
	logic                tck_rise;
	logic                tck_fall;
	dr_sel_t             dr_sel;
	logic                bsr_so;
	logic [BSR_W-1:0]    bsr_par_in;
	logic [BSR_W-1:0]    bsr_upd;
	logic                bsr_capture;
	logic                bsr_shift;
	logic                bsr_update;
	logic                drive_from_bsr;

	assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};

	jtag_pin_sync #(
		.WIDTH     ($bits(jtag_pins_t)),
		.RESET_VAL (PINS_RESET)
	) u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   (pins_raw),
		.sync_o    (pins)
	);

	jtag_pin_sync #(
		.WIDTH     (IO_COUNT),
		.RESET_VAL ('0)
	) u_pad_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   (pad_in_i),
		.sync_o    (pad_in_s)
	);

	// TMS and TDI travel with TCK through equal stages, so they are sampled consistently.
	assign tck_rise = pins.tck & ~st_r.tck_d;
	assign tck_fall = ~pins.tck & st_r.tck_d;
	assign dr_sel   = dr_select(st_r.ir);

	// ----------------------------------------------------------------
	// Boundary scan chain
	// ----------------------------------------------------------------

	// Strobes are one reference cycle long, taken at the TCK rise that leaves the state.
	assign bsr_capture = tck_rise && st_r.state == CAP_DR && dr_sel == DR_BSR;
	assign bsr_shift   = tck_rise && st_r.state == SH_DR && dr_sel == DR_BSR;
	assign bsr_update  = tck_rise && st_r.state == UP_DR && dr_sel == DR_BSR;

	// Input cells see the gated input buffer, so an unprogrammed SAMPLE captures zeros.
	always_comb begin
		bsr_par_in = '0;
		for (int k = 0; k < IO_COUNT; k++) begin
			bsr_par_in[k*CELLS_PER_IO+CELL_IN]  = pad_in_s[k] & programmed_i;
			bsr_par_in[k*CELLS_PER_IO+CELL_OUT] = core_out_i[k];
			bsr_par_in[k*CELLS_PER_IO+CELL_OE]  = core_oe_i[k];
		end
	end

	jtag_bsr_chain u_bsr (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.capture_i (bsr_capture),
		.shift_i   (bsr_shift),
		.update_i  (bsr_update),
		.tdi_i     (pins.tdi),
		.par_in_i  (bsr_par_in),
		.so_o      (bsr_so),
		.par_out_o (bsr_upd)
	);

	// ----------------------------------------------------------------
	// Controller, instruction and data registers
	// ----------------------------------------------------------------
	assign drive_from_bsr = st_r.ir == OP_EXTEST || st_r.ir == OP_CLAMP;

	always_comb begin
		st_nxt         = st_r;
		st_nxt.tck_d   = pins.tck;
		st_nxt.io_en   = programmed_i;
		if (tck_rise) begin
			st_nxt.state = tap_next(st_r.state, pins.tms);
			case (st_r.state)
				TLR:    st_nxt.ir = OP_IDCODE;
				CAP_IR: st_nxt.ir_sr = IR_CAPTURE;
				SH_IR:  st_nxt.ir_sr = {pins.tdi, st_r.ir_sr[IR_W-1:1]};
				UP_IR:  st_nxt.ir = st_r.ir_sr;
				CAP_DR: begin
					st_nxt.bypass = 1'b0;
					st_nxt.id_sr  = (st_r.ir == OP_USERCODE) ? USERCODE : ID_WORD;
				end
				SH_DR: begin
					st_nxt.bypass = pins.tdi;
					st_nxt.id_sr  = {pins.tdi, st_r.id_sr[ID_W-1:1]};
				end
				default: begin
				end
			endcase
		end
		// TDO moves only on the falling edge, half a TCK after the shift.
		if (tck_fall) begin
			st_nxt.tdo_oe = st_r.state == SH_DR || st_r.state == SH_IR;
			if (st_r.state == SH_IR) begin
				st_nxt.tdo = st_r.ir_sr[0];
			end else begin
				unique case (dr_sel)
					DR_ID:   st_nxt.tdo = st_r.id_sr[0];
					DR_BSR:  st_nxt.tdo = bsr_so;
					default: st_nxt.tdo = st_r.bypass;
				endcase
			end
		end
		// TRST acts on every reference cycle, with or without TCK edges.
		if (!pins.trst_n) begin
			st_nxt.state  = TLR;
			st_nxt.ir     = OP_IDCODE;
			st_nxt.tdo_oe = 1'b0;
		end
		// Pad drive: boundary values under EXTEST or CLAMP, off under HIGHZ.
		for (int k = 0; k < IO_COUNT; k++) begin
			st_nxt.pad_out[k] = drive_from_bsr ? bsr_upd[k*CELLS_PER_IO+CELL_OUT] : core_out_i[k];
			st_nxt.pad_oe[k]  = (drive_from_bsr ? bsr_upd[k*CELLS_PER_IO+CELL_OE] : core_oe_i[k])
				& (st_r.ir != OP_HIGHZ) & programmed_i;
			st_nxt.core_in[k] = pad_in_s[k] & programmed_i;
		end
	end

	// Power-up reset lands in Test-Logic-Reset with no TCK needed.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_r        <= '0;
			st_r.state  <= TLR;
			st_r.ir     <= OP_IDCODE;
			st_r.ir_sr  <= IR_CAPTURE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tdo_o     = st_r.tdo;
	assign tdo_oe_o  = st_r.tdo_oe;
	assign io_en_o   = st_r.io_en;
	assign core_in_o = st_r.core_in;
	assign pad_out_o = st_r.pad_out;
	assign pad_oe_o  = st_r.pad_oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Helper: consecutive TCK rises seen with TMS high, saturating.
	logic [2:0] tms_hi_cnt_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tms_hi_cnt_r <= '0;
		end else if (tck_rise) begin
			if (!pins.tms) begin
				tms_hi_cnt_r <= '0;
			end else if (tms_hi_cnt_r != TMS_RESET_CYCLES) begin
				tms_hi_cnt_r <= tms_hi_cnt_r + 3'h1;
			end
		end
	end

	property p_five_tms;
		tms_hi_cnt_r == TMS_RESET_CYCLES |-> st_r.state == TLR;
	endproperty
	a_five_tms: assert property (p_five_tms) else $error("five TMS highs missed reset");

	property p_trst;
		!pins.trst_n |=> st_r.state == TLR && st_r.ir == OP_IDCODE && !tdo_oe_o;
	endproperty
	a_trst: assert property (p_trst) else $error("TRST did not force reset");

	property p_step_on_rise;
		!tck_rise && pins.trst_n |=> $stable(st_r.state);
	endproperty
	a_step_on_rise: assert property (p_step_on_rise) else $error("state moved without TCK rise");

	property p_tlr_ir;
		tck_rise && st_r.state == TLR |=> st_r.ir == OP_IDCODE;
	endproperty
	a_tlr_ir: assert property (p_tlr_ir) else $error("reset did not load identification");

	property p_tdo_fall;
		!tck_fall |=> $stable(tdo_o);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("TDO changed off a TCK fall");

	property p_unprog;
		!programmed_i ##1 !programmed_i |-> !io_en_o && core_in_o == '0 && pad_oe_o == '0;
	endproperty
	a_unprog: assert property (p_unprog) else $error("user pins live while unprogrammed");

	property p_sample_unprog;
		bsr_capture && !programmed_i |-> bsr_par_in[CELL_IN] == 1'b0;
	endproperty
	a_sample_unprog: assert property (p_sample_unprog) else $error("SAMPLE saw a pin unprogrammed");

	// Helper: high from the capture rise to the next fall; later falls show TDI data.
	logic cap_pend_r;
	always_ff @(posedge ref_clk_i) begin
		cap_pend_r <= rst_n_i && !tck_fall && (cap_pend_r || (tck_rise && st_r.state == CAP_DR));
	end
	property p_bypass_cap;
		tck_fall && cap_pend_r && st_r.state == SH_DR && dr_sel == DR_BYPASS |=> tdo_o == 1'b0;
	endproperty
	a_bypass_cap: assert property (p_bypass_cap) else $error("bypass did not capture zero");

	property p_id_cap;
		tck_rise && st_r.state == CAP_DR && st_r.ir == OP_IDCODE |=> st_r.id_sr == ID_WORD;
	endproperty
	a_id_cap: assert property (p_id_cap) else $error("identification word not captured");

	property p_highz;
		st_r.ir == OP_HIGHZ ##1 st_r.ir == OP_HIGHZ |-> pad_oe_o == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("HIGHZ left a pin driven");

	property p_extest;
		programmed_i && st_r.ir == OP_EXTEST ##1 st_r.ir == OP_EXTEST
			|-> pad_out_o[0] == $past(bsr_upd[CELL_OUT]);
	endproperty
	a_extest: assert property (p_extest) else $error("EXTEST pin not from update cell");

	c_shift_ir:  cover property (tck_rise && st_r.state == UP_IR && st_r.ir_sr == OP_EXTEST);
	c_id_shift:  cover property (tck_rise && st_r.state == SH_DR && dr_sel == DR_ID);
	c_bsr_upd:   cover property (bsr_update);
	c_five_tms:  cover property (tms_hi_cnt_r == TMS_RESET_CYCLES);

endmodule

// *** dv/jtag_tester.sv ***
// Behavioural boundary scan tester that drives the test port pins from the far side.
`timescale 1ns/1ns
module jtag_tester (
	// Test port pins.
	output logic        tck_o,
	output logic        tms_o,
	output logic        tdi_o,
	output logic        trst_n_o,
	input  wire logic   tdo_i,
	input  wire logic   tdo_oe_i,
	// Scan results.
	output logic        done_o,
	output logic [31:0] data_o
);
	// Half period of the link clock; it stands low between frames.
	localparam int HALF = 160;

	// Idle levels match the pull-ups on mode, data and reset pins.
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b1;
		done_o = 1'b0;
		data_o = 32'h0;
	end

	// One link clock: levels change after the fall and hold across the rise.
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		#HALF tck_o = 1'b1;
		#HALF tdo = tdo_i;
		tck_o = 1'b0;
	endtask

	// -----------------------------------------------------------------
	// Scan from Run-Test/Idle and back again
	// -----------------------------------------------------------------
	// A bit seen while the output driver is off reads as unknown, so it never matches.
	task automatic scan(input logic ir, input int n, input logic [31:0] din);
		logic        t;
		logic [31:0] q;
		q = 32'h0;
		tick(1'b1, 1'b1, t);
		if (ir) begin
			tick(1'b1, 1'b1, t);
		end
		tick(1'b0, 1'b1, t);
		tick(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], t);
			q[i] = tdo_oe_i ? t : 1'bx;
		end
		tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
		data_o = q;
		done_o = 1'b1;
		// The pulse ends in the background, so the next frame keeps its place on the grid.
		done_o <= #1 1'b0;
	endtask

	// Five high mode samples, then one low to settle in Run-Test/Idle.
	task automatic reset5();
		logic t;
		repeat (5) tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
	endtask

	// Test reset pulse while the link clock stands still.
	task automatic trst();
		logic t;
		trst_n_o = 1'b0;
		#400 trst_n_o = 1'b1;
		#400 tick(1'b0, 1'b1, t);
	endtask
endmodule

// *** dv/jtag_tap_bench.sv ***
// Self-checking testbench of the boundary scan test port.
`timescale 1ns/1ns
module jtag_tap_bench;
	import jtag_tap_pkg::*;

	// -----------------------------------------------------------------
	// Constants and signals
	// -----------------------------------------------------------------
	localparam logic [3:0]  ID_VER   = 4'h3;        // Arbitrary value.
	localparam logic [15:0] ID_PRT   = 16'h0a5c;    // Arbitrary value.
	localparam logic [10:0] ID_MFR   = 11'h2b1;     // Arbitrary value.
	localparam logic [31:0] USER_VAL = 32'h5a5a_c3c3;
	localparam logic [31:0] ID_EXP   = {ID_VER, ID_PRT, ID_MFR, ID_FIXED_LSB};
	localparam logic [7:0]  OPS [6]  = '{OP_CLAMP, OP_HIGHZ, OP_USERCODE, OP_IDCODE,
		OP_BYPASS, 8'h3c};
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
	} note_t;

	logic        ref_clk = 1'b0;
	logic        rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, programmed, io_en, done, t;
	logic [3:0]  core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
	logic [31:0] sdata, seed, p, d, e;
	note_t       notes[$];
	note_t       cur;
	int          errors = 0;
	int          total_checks = 0;

	always #20 ref_clk = ~ref_clk;

	jtag_tap #(.ID_VERSION(ID_VER), .ID_PART(ID_PRT), .ID_MAKER(ID_MFR),
		.USERCODE(USER_VAL)) uut (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .programmed_i(programmed),
		.io_en_o(io_en), .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe));

	jtag_tester tester (
		.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo),
		.tdo_oe_i(tdo_oe), .done_o(done), .data_o(sdata));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// Pin k owns cells 3k..3k+2; these map pins to cells and back.
	function automatic logic [11:0] cells(input logic [3:0] v, input int pos);
		logic [11:0] c;
		c = 12'h000;
		for (int k = 0; k < IO_COUNT; k++) c[CELLS_PER_IO * k + pos] = v[k];
		return c;
	endfunction

	function automatic logic [3:0] pick(input logic [11:0] c, input int pos);
		logic [3:0] v;
		for (int k = 0; k < IO_COUNT; k++) v[k] = c[CELLS_PER_IO * k + pos];
		return v;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// The note is queued first, so the monitor finds it when the result lands.
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		input logic [31:0] exp, input logic [31:0] mask);
		notes.push_back('{exp, mask});
		tester.scan(ir, n, din);
	endtask

	// Every instruction load also shows the fixed capture pattern.
	task automatic ld(input logic [7:0] op);
		scan(1'b1, IR_W, {24'h0, op}, {24'h0, IR_CAPTURE}, 32'h0000_00ff);
	endtask

	task automatic pads(input logic [3:0] out, input logic [3:0] oe, input logic see_out);
		repeat (4) @(negedge ref_clk);
		chk({28'h0, pad_oe}, {28'h0, oe});
		if (see_out) begin
			chk({28'h0, pad_out}, {28'h0, out});
		end
	endtask

	// Monitor: each finished scan is compared with the oldest note.
	always @(posedge done) begin
		if (notes.size() == 0) begin
			chk(sdata, 32'hx);
		end else begin
			cur = notes.pop_front();
			chk(sdata & cur.mask, cur.exp & cur.mask);
		end
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The whole run needs about 0.2 ms of link traffic; allow five times that.
	initial begin
		#1000000;
		errors++;
		$display("Error at %0t ns: seen %h expected %h", $time, 1'b0, 1'b1);
		close_out();
	end

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		seed = 32'h5fa6;
		rst_n = 1'b0;
		programmed = 1'b0;
		core_out = 4'h0;
		core_oe = 4'h0;
		pad_in = 4'hf;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		// Reset leaves the identification word selected and every pin off.
		tester.tick(1'b0, 1'b1, t);
		scan(1'b0, 32, rnd(), ID_EXP, 32'hffff_ffff);
		chk({31'h0, io_en}, 32'h0);
		chk({28'h0, core_in}, 32'h0);
		chk({28'h0, pad_oe}, 32'h0);
		// Unprogrammed sampling must not see the high pins.
		ld(OP_SAMPLE);
		p = rnd();
		scan(1'b0, 32, p, {p[19:0], 12'h000}, 32'hffff_ffff);
		$display("Test unprogrammed done");
		p = rnd();
		@(negedge ref_clk);
		programmed = 1'b1;
		pad_in = p[3:0];
		core_out = p[7:4];
		core_oe = p[11:8];
		repeat (6) @(negedge ref_clk);
		chk({31'h0, io_en}, 32'h1);
		chk({28'h0, core_in}, {28'h0, pad_in});
		pads(core_out, core_oe, 1'b1);
		// Sampling sees pins and preloads the latches that the next test drives out.
		// Of 32 bits shifted, the last twelve stay in the chain: d[31:20] is preloaded.
		for (int r = 0; r < 2; r++) begin
			d = rnd();
			e = {d[19:0], cells(pad_in, CELL_IN) | cells(core_out, CELL_OUT)
				| cells(core_oe, CELL_OE)};
			scan(1'b0, 32, d, e, 32'hffff_ffff);
			if (r == 0) begin
				ld(OP_EXTEST);
			end
			pads(pick(d[31:20], CELL_OUT), pick(d[31:20], CELL_OE), 1'b1);
		end
		$display("Test boundary done");
		// Each remaining opcode picks its path and its pin behaviour.
		foreach (OPS[i]) begin
			p = rnd();
			ld(OPS[i]);
			case (OPS[i])
				OP_USERCODE: e = USER_VAL;
				OP_IDCODE: e = ID_EXP;
				default: e = {p[30:0], 1'b0};
			endcase
			scan(1'b0, 32, p, e, 32'hffff_ffff);
			if (OPS[i] == OP_CLAMP) begin
				pads(pick(d[31:20], CELL_OUT), pick(d[31:20], CELL_OE), 1'b1);
			end else if (OPS[i] == OP_HIGHZ) begin
				pads(4'h0, 4'h0, 1'b0);
			end else begin
				pads(core_out, core_oe, 1'b1);
			end
		end
		$display("Test opcodes done");
		// Five high mode samples from inside a data shift must reach reset.
		ld(OP_BYPASS);
		tester.tick(1'b1, 1'b1, t);
		tester.tick(1'b0, 1'b1, t);
		tester.tick(1'b0, 1'b0, t);
		tester.reset5();
		scan(1'b0, 32, rnd(), ID_EXP, 32'hffff_ffff);
		// Test reset with the link clock still.
		ld(OP_BYPASS);
		tester.trst();
		scan(1'b0, 32, rnd(), ID_EXP, 32'hffff_ffff);
		$display("Test resets done");
		close_out();
	end
endmodule
